// >>> design/alvgbc_regs.sv
/*
 * Configuration bank of a mono amplifier: TDM audio transmit, digital volume,
 * voltage limiter settings and the inter-chip gain bus pin.
 * Assumes an Avalon-MM master on clk_sys, TDM bit clock and frame sync arriving
 * as asynchronous pins, and an audio sample stream on clk_sys.
 */
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
module alvgbc_regs #(
	parameter int SAMPLE_W = 24,
	parameter int CNT_W    = 11
) (
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	// avalon-mm slave
	input  wire logic [7:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// audio samples in
	input  wire logic [SAMPLE_W-1:0]   smp_data,
	input  wire logic                  smp_valid,
	output logic                       smp_ready,
	// tdm transmit pins
	input  wire logic                  tdm_bclk,
	input  wire logic                  tdm_fsync,
	output logic                       tdm_dout,
	output logic                       tdm_dout_oe,
	// inter chip gain bus pin
	input  wire logic                  inter_chip_gain_bus_in,
	output logic                       inter_chip_gain_bus_out,
	output logic                       inter_chip_gain_bus_oe,
	// decoded settings for the signal path
	output logic [7:0]                 volume_level_code,
	output logic                       volume_mute,
	output logic                       limiter_enable,
	output logic                       limiter_rail_select,
	output logic                       limiter_headroom_enable,
	output logic [3:0]                 limiter_ceiling_db,
	output logic [17:0]                limiter_attack_us_per_db,
	output logic [14:0]                limiter_release_ms_per_db,
	output logic [9:0]                 limiter_hold_ms
);

	// the serializer indexes a 24-bit sample and the counter must span a whole frame
	if (SAMPLE_W != 24 || CNT_W < 11)
	begin : gen_param_check
		$error("alvgbc_regs: sample width must be 24, counter at least 11 bits");
	end

	////////////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] tdm_tx_q, ceiling_q, volume_q, lim_atk_q, lim_rel_q, gbus_q, pin_cfg_q;
	logic       gpo_level_q;
	logic [7:0] partner_gain_q;
	logic       partner_valid_q;
	logic       gb_in_s1, gb_in_s2;
	logic       wait_q;
	logic [31:0] rdata_q;
	logic [5:0] idx;
	logic       wr_lo;
	logic [7:0] rd_mux;

	assign idx      = avs_address[7:2];
	assign wr_lo    = avs_write && !wait_q && avs_byteenable[0];

	// waitrequest drops for one cycle, one cycle after the request is seen
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			wait_q <= 1'b1;
		else
			wait_q <= !((avs_read || avs_write) && wait_q);
	end

	// writes land on the edge that sees waitrequest low
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tdm_tx_q    <= alvgbc_pkg::RST_TDM_TX;
			ceiling_q   <= alvgbc_pkg::RST_CEILING;
			volume_q    <= alvgbc_pkg::RST_VOLUME;
			lim_atk_q   <= alvgbc_pkg::RST_LIM_ATK;
			lim_rel_q   <= alvgbc_pkg::RST_LIM_REL;
			gbus_q      <= alvgbc_pkg::RST_GBUS;
			pin_cfg_q   <= alvgbc_pkg::RST_PIN_CFG;
			gpo_level_q <= 1'b0;
		end
		else if (wr_lo)
		begin
			unique case (idx)
				alvgbc_pkg::IDX_TDM_TX:  tdm_tx_q    <= avs_writedata[7:0];
				alvgbc_pkg::IDX_CEILING: ceiling_q   <= avs_writedata[7:0] & alvgbc_pkg::MASK_CEILING;
				alvgbc_pkg::IDX_VOLUME:  volume_q    <= avs_writedata[7:0];
				alvgbc_pkg::IDX_LIM_ATK: lim_atk_q   <= (avs_writedata[7:0] & alvgbc_pkg::MASK_LIM_ATK)
					| alvgbc_pkg::FIXED_LIM_ATK;
				alvgbc_pkg::IDX_LIM_REL: lim_rel_q   <= avs_writedata[7:0] & alvgbc_pkg::MASK_LIM_REL;
				alvgbc_pkg::IDX_GBUS:    gbus_q      <= avs_writedata[7:0];
				alvgbc_pkg::IDX_PIN_CFG: pin_cfg_q   <= avs_writedata[7:0] & alvgbc_pkg::MASK_PIN_CFG;
				alvgbc_pkg::IDX_PIN_CTL: gpo_level_q <= avs_writedata[0];
				default:                 ;   // unmapped and read-only: ignored
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		unique case (idx)
			alvgbc_pkg::IDX_TDM_TX:  rd_mux = tdm_tx_q;
			alvgbc_pkg::IDX_CEILING: rd_mux = ceiling_q;
			alvgbc_pkg::IDX_VOLUME:  rd_mux = volume_q;
			alvgbc_pkg::IDX_LIM_ATK: rd_mux = lim_atk_q;
			alvgbc_pkg::IDX_LIM_REL: rd_mux = lim_rel_q;
			alvgbc_pkg::IDX_GBUS:    rd_mux = gbus_q;
			alvgbc_pkg::IDX_PIN_CFG: rd_mux = pin_cfg_q;
			alvgbc_pkg::IDX_PIN_CTL: rd_mux = {5'h00, partner_valid_q, gb_in_s2, gpo_level_q};
			alvgbc_pkg::IDX_PARTNER: rd_mux = partner_gain_q;
			default:                 rd_mux = 8'h00;
		endcase
	end

	// read data is captured on the request's first cycle and held
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 32'h0000_0000;
		else if (avs_read && wait_q)
			rdata_q <= {24'h000000, rd_mux};
	end

	////////////////////////////////////////////////////////////////////////////
	// decoded settings, registered so the signal path sees clean levels

	logic [3:0] atk_code, rel_code, ceil_code;
	logic [2:0] hold_code;
	assign atk_code  = lim_atk_q[4:1];
	assign rel_code  = lim_rel_q[6:3];
	assign hold_code = lim_rel_q[2:0];
	assign ceil_code = ceiling_q[7:4];

	// reserved codes decode to zero so the path can hold its last safe value
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			volume_level_code         <= 8'h00;
			volume_mute               <= 1'b0;
			limiter_enable            <= 1'b0;
			limiter_rail_select       <= 1'b0;
			limiter_headroom_enable   <= 1'b0;
			limiter_ceiling_db        <= 4'h0;
			limiter_attack_us_per_db  <= 18'h00000;
			limiter_release_ms_per_db <= 15'h0000;
			limiter_hold_ms           <= 10'h000;
		end
		else
		begin
			volume_level_code       <= volume_q;
			volume_mute             <= volume_q > alvgbc_pkg::VOL_MAX_CODE;
			limiter_enable          <= lim_atk_q[alvgbc_pkg::POS_LIMITER_ENABLE];
			limiter_rail_select     <= lim_atk_q[alvgbc_pkg::POS_RAIL_SEL];
			limiter_headroom_enable <= lim_atk_q[alvgbc_pkg::POS_HEADROOM];
			limiter_ceiling_db      <= (ceil_code <= alvgbc_pkg::CEIL_MAX_CODE) ? ceil_code + 4'h1 : 4'h0;
			limiter_attack_us_per_db  <= (atk_code <= alvgbc_pkg::RATE_MAX_CODE)
				? alvgbc_pkg::ATK_BASE_US << atk_code : 18'h00000;
			limiter_release_ms_per_db <= (rel_code <= alvgbc_pkg::RATE_MAX_CODE)
				? alvgbc_pkg::REL_BASE_MS << rel_code : 15'h0000;
			limiter_hold_ms         <= alvgbc_pkg::HOLD_MS[hold_code];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// two-entry sample buffer; stalls the source when both entries hold data

	logic [SAMPLE_W-1:0] buf_mem [2];
	logic                buf_wp_q, buf_rp_q;
	logic [1:0]          buf_cnt_q, buf_cnt_d;
	logic                buf_push, buf_pop;
	logic                ready_q;

	assign buf_push = smp_valid && ready_q;
	assign buf_cnt_d = buf_cnt_q + {1'b0, buf_push} - {1'b0, buf_pop};

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			buf_wp_q  <= 1'b0;
			buf_rp_q  <= 1'b0;
			buf_cnt_q <= 2'h0;
			ready_q   <= 1'b1;
		end
		else
		begin
			if (buf_push)
				buf_wp_q <= !buf_wp_q;
			if (buf_pop)
				buf_rp_q <= !buf_rp_q;
			buf_cnt_q <= buf_cnt_d;
			ready_q   <= buf_cnt_d != 2'h2;
		end
	end

	// storage has no reset; contents only matter once counted in
	always_ff @(posedge clk_sys)
	begin
		if (buf_push)
			buf_mem[buf_wp_q] <= smp_data;
	end

	////////////////////////////////////////////////////////////////////////////
	// tdm pin synchronisers and bit counter

	logic bclk_s1, bclk_s2, bclk_s3, fs_s1, fs_s2, fs_last_q;
	logic bclk_rise, frame_start;
	logic [CNT_W-1:0] bit_cnt_q, bit_cnt_d;

	// two flops per pin; a third bclk stage is only for the edge detect
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			bclk_s1 <= 1'b0;
			bclk_s2 <= 1'b0;
			bclk_s3 <= 1'b0;
			fs_s1   <= 1'b0;
			fs_s2   <= 1'b0;
			gb_in_s1 <= 1'b0;
			gb_in_s2 <= 1'b0;
		end
		else
		begin
			bclk_s1 <= tdm_bclk;
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			fs_s1   <= tdm_fsync;
			fs_s2   <= fs_s1;
			gb_in_s1 <= inter_chip_gain_bus_in;
			gb_in_s2 <= gb_in_s1;
		end
	end

	assign bclk_rise   = bclk_s2 && !bclk_s3;
	assign frame_start = bclk_rise && fs_s2 && !fs_last_q;
	// count of the bit this rise opens; slots decode from it so no bit goes out one bit late
	assign bit_cnt_d   = frame_start ? '0 : (bit_cnt_q != '1) ? bit_cnt_q + 1'b1 : bit_cnt_q;

	// bit position within the frame, saturating so a lost sync goes quiet
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_cnt_q <= '1;
			fs_last_q <= 1'b0;
		end
		else if (bclk_rise)
		begin
			fs_last_q <= fs_s2;
			bit_cnt_q <= bit_cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// audio slot serializer

	logic [SAMPLE_W-1:0] cur_smp_q, tx_smp;
	logic [CNT_W-1:0]    slot_start, slot_bits, slot_off;
	logic [5:0]          slot_sel;
	logic                in_slot, tx_en, wide;
	logic [4:0]          bit_sel;

	assign slot_sel   = tdm_tx_q[5:0];
	assign wide       = tdm_tx_q[alvgbc_pkg::POS_SLOT_WIDTH];
	assign tx_en      = tdm_tx_q[alvgbc_pkg::POS_TX_EN];
	assign slot_bits  = wide ? CNT_W'(24) : CNT_W'(16);
	assign slot_start = wide ? CNT_W'({slot_sel, 4'h0}) + CNT_W'({slot_sel, 3'h0})
		: CNT_W'({slot_sel, 4'h0});
	assign slot_off   = bit_cnt_d - slot_start;
	assign in_slot    = (bit_cnt_d >= slot_start) && (slot_off < slot_bits) && (bit_cnt_d != '1);
	assign bit_sel    = 5'd23 - slot_off[4:0];
	// the sample taken at frame start is sent from that very rise; underrun sends silence
	assign tx_smp     = frame_start ? ((buf_cnt_q != 2'h0) ? buf_mem[buf_rp_q] : '0) : cur_smp_q;
	// one sample per frame leaves the buffer, sent or not, so the source keeps pace
	assign buf_pop    = frame_start && (buf_cnt_q != 2'h0);

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			cur_smp_q <= '0;
		else if (frame_start)
			cur_smp_q <= tx_smp;
	end

	// 16-bit slots carry the top 16 bits of the sample, msb first
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tdm_dout    <= 1'b0;
			tdm_dout_oe <= 1'b0;
		end
		else if (!tx_en)
		begin
			tdm_dout_oe <= 1'b0;                                          // silent at once, not next bit
			tdm_dout    <= 1'b0;
		end
		else if (bclk_rise)
		begin
			tdm_dout_oe <= in_slot;
			tdm_dout    <= in_slot && tx_smp[bit_sel];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// inter chip gain bus: eight 8-bit slots from frame start

	alvgbc_pkg::alvgbc_pin_fn_t pin_fn;
	logic [2:0] own_num, gb_slot, gb_bit;
	logic [3:0] partner_num;
	logic       gb_en, gb_in_frame, own_slot, partner_slot;
	logic [7:0] partner_sh_q;

	assign pin_fn       = alvgbc_pkg::alvgbc_pin_fn_t'(pin_cfg_q[4:2]);
	assign own_num      = gbus_q[2:0];
	assign partner_num  = gbus_q[6:3];
	assign gb_en        = gbus_q[alvgbc_pkg::POS_GB_EN];
	assign gb_in_frame  = bit_cnt_d < CNT_W'(alvgbc_pkg::GB_SLOTS * alvgbc_pkg::GB_SLOT_BITS);
	assign gb_slot      = bit_cnt_d[5:3];
	assign gb_bit       = bit_cnt_d[2:0];
	assign own_slot     = gb_in_frame && (gb_slot == own_num);
	assign partner_slot = gb_in_frame && (partner_num < alvgbc_pkg::PAIR_NONE_MIN)
		&& (gb_slot == partner_num[2:0]);

	// pin drive by function; a disabled pin never drives
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			inter_chip_gain_bus_oe  <= 1'b0;
			inter_chip_gain_bus_out <= 1'b0;
		end
		else if (!gb_en)
		begin
			inter_chip_gain_bus_oe  <= 1'b0;
			inter_chip_gain_bus_out <= 1'b0;
		end
		else if (pin_fn == alvgbc_pkg::ALVGBC_PIN_GPO)
		begin
			inter_chip_gain_bus_oe  <= 1'b1;
			inter_chip_gain_bus_out <= gpo_level_q;
		end
		else if (pin_fn == alvgbc_pkg::ALVGBC_PIN_SLOT)
		begin
			if (bclk_rise)
			begin
				inter_chip_gain_bus_oe  <= own_slot;
				inter_chip_gain_bus_out <= own_slot && volume_q[3'd7 - gb_bit];
			end
		end
		else
		begin
			inter_chip_gain_bus_oe  <= 1'b0;
			inter_chip_gain_bus_out <= 1'b0;
		end
	end

	// partner gain capture; a new frame's byte overwrites the last one
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			partner_sh_q    <= 8'h00;
			partner_gain_q  <= 8'h00;
			partner_valid_q <= 1'b0;
		end
		else if (!gb_en || pin_fn != alvgbc_pkg::ALVGBC_PIN_SLOT
			|| partner_num >= alvgbc_pkg::PAIR_NONE_MIN)
			partner_valid_q <= 1'b0;
		else if (bclk_rise && partner_slot)
		begin
			partner_sh_q <= {partner_sh_q[6:0], gb_in_s2};
			if (gb_bit == 3'h7)
			begin
				partner_gain_q  <= {partner_sh_q[6:0], gb_in_s2};
				partner_valid_q <= 1'b1;
			end
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign smp_ready       = ready_q;

	////////////////////////////////////////////////////////////////////////////
	// checks

	bus_answer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		(avs_read || avs_write) && wait_q |=> !wait_q)
		else $error("waitrequest did not drop one cycle after request");
	vol_mute_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$stable(volume_q) && volume_q > 8'hC8 |=> volume_mute)
		else $error("volume above C8h not muted");
	ceil_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$stable(ceiling_q) && ceiling_q[7:4] == 4'h0 |=> limiter_ceiling_db == 4'h1)
		else $error("ceiling code 0 not 1 dB");
	atk_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$stable(lim_atk_q) && lim_atk_q[4:1] == 4'hD |=> limiter_attack_us_per_db == 18'd163840)
		else $error("attack code D wrong");
	rel_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$stable(lim_rel_q) && lim_rel_q[6:3] == 4'h6 |=> limiter_release_ms_per_db == 15'd128)
		else $error("release code 6 wrong");
	hold_map_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$stable(lim_rel_q) && lim_rel_q[2:0] == 3'h6 |=> limiter_hold_ms == 10'd500)
		else $error("hold code 6 not 500 ms");
	tx_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!tx_en && $past(!tx_en) |-> !tdm_dout_oe)
		else $error("audio driven while transmit disabled");
	gb_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		!gb_en ##1 !gb_en |-> !inter_chip_gain_bus_oe)
		else $error("gain bus pin driven while disabled");
	lim_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(lim_atk_q[0]) |=> limiter_enable)
		else $error("limiter enable did not follow register");
	buf_full_a: assert property (@(posedge clk_sys) disable iff (!nrst)
		buf_cnt_q == 2'h2 |-> !ready_q)
		else $error("buffer full but ready high");

	write_cov_c:   cover property (@(posedge clk_sys) disable iff (!nrst) wr_lo);
	read_cov_c:    cover property (@(posedge clk_sys) disable iff (!nrst) avs_read && !wait_q);
	stall_cov_c:   cover property (@(posedge clk_sys) disable iff (!nrst) smp_valid && !ready_q);
	partner_cov_c: cover property (@(posedge clk_sys) disable iff (!nrst) $rose(partner_valid_q));

endmodule : alvgbc_regs

// >>> pkg/alvgbc_pkg.sv
/*
 * Constants for the amplifier configuration bank: register indices, field
 * positions, reset values and decode tables.
 * Assumes a 32-bit Avalon-MM bus; each register index sits at byte address 4*index.
 */
package alvgbc_pkg;

	// register indices; byte address is four times the index
	localparam logic [5:0] IDX_PIN_CFG   = 6'h15;
	localparam logic [5:0] IDX_TDM_TX    = 6'h16;
	localparam logic [5:0] IDX_CEILING   = 6'h17;
	localparam logic [5:0] IDX_VOLUME    = 6'h1A;
	localparam logic [5:0] IDX_LIM_ATK   = 6'h1B;
	localparam logic [5:0] IDX_LIM_REL   = 6'h1C;
	localparam logic [5:0] IDX_GBUS      = 6'h1D;
	localparam logic [5:0] IDX_PIN_CTL   = 6'h21;
	localparam logic [5:0] IDX_PARTNER   = 6'h22;

	// reset values
	localparam logic [7:0] RST_TDM_TX  = 8'h12;
	localparam logic [7:0] RST_CEILING = 8'h80;
	localparam logic [7:0] RST_VOLUME  = 8'h00;
	localparam logic [7:0] RST_LIM_ATK = 8'h62;
	localparam logic [7:0] RST_LIM_REL = 8'h36;
	localparam logic [7:0] RST_GBUS    = 8'h00;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;

	// field positions
	localparam int POS_SLOT_WIDTH = 7;
	localparam int POS_TX_EN      = 6;
	localparam int POS_RAIL_SEL   = 7;
	localparam int POS_HEADROOM   = 5;
	localparam int POS_LIMITER_ENABLE     = 0;
	localparam int POS_GB_EN      = 7;

	// read masks: reserved bits read zero, bit 6 of the attack register reads one
	localparam logic [7:0] MASK_CEILING = 8'hF0;
	localparam logic [7:0] MASK_LIM_REL = 8'h7F;
	localparam logic [7:0] MASK_LIM_ATK = 8'hBF;
	localparam logic [7:0] FIXED_LIM_ATK = 8'h40;
	localparam logic [7:0] MASK_PIN_CFG = 8'h1C;

	// decode limits
	localparam logic [7:0] VOL_MAX_CODE   = 8'hC8;
	localparam logic [3:0] CEIL_MAX_CODE  = 4'hE;
	localparam logic [3:0] RATE_MAX_CODE  = 4'hD;
	localparam logic [17:0] ATK_BASE_US   = 18'h00014;
	localparam logic [14:0] REL_BASE_MS   = 15'h0002;
	localparam logic [3:0] PAIR_NONE_MIN  = 4'h8;

	// hold time table in ms, indexed by code; code 0 reserved reads as 0
	localparam logic [9:0] HOLD_MS [8] = '{10'h000, 10'h00A, 10'h019, 10'h032,
		10'h064, 10'h0FA, 10'h1F4, 10'h3E8};

	// gain bus pin functions
	typedef enum logic [2:0] {
		ALVGBC_PIN_SLOT = 3'h0,
		ALVGBC_PIN_OFF  = 3'h2,
		ALVGBC_PIN_GPI  = 3'h3,
		ALVGBC_PIN_GPO  = 3'h4
	} alvgbc_pin_fn_t;

	// link timing
	localparam int GB_SLOT_BITS = 8;
	localparam int GB_SLOTS     = 8;

endpackage : alvgbc_pkg

// >>> test/alvgbc_peer.sv
/*
 * Far-side model: the TDM host that makes bit clock and frame sync, and one
 * gain bus peer that drives its byte in slot PSLOT of each 64-bit frame.
 * Assumes clk_sys at 100 MHz; one bit lasts 12 clk_sys cycles.
 */
`timescale 1ns/1ps
module alvgbc_peer #(
	parameter int         PSLOT = 3,
	parameter logic [7:0] PBYTE = 8'h5A
) (
	input  wire logic clk_sys,
	input  wire logic run,
	output logic      bclk,
	output logic      fsync,
	output logic      gb_out
);
	logic [3:0] div_q;
	logic [5:0] nb_q;
	logic [5:0] nx;
	assign nx = nb_q + 6'h01;
	////////////////////////////////////////////////////////////////////////////////
	// start idle; no frame sync until run so the buffer can be filled first
	initial
	begin
		div_q = 4'h0;
		nb_q = 6'h3F;
		bclk = 1'b0;
		fsync = 1'b0;
		gb_out = 1'b0;
	end
	// 6 high and 6 low so the 2-flop sync sees each phase; data moves on the fall
	always @(posedge clk_sys)
	begin
		div_q <= (div_q == 4'hB) ? 4'h0 : div_q + 4'h1;
		if (div_q == 4'h5)
			bclk <= 1'b1;
		if (div_q == 4'hB)
		begin
			bclk <= 1'b0;
			nb_q <= nx;
			fsync <= run && (nx == 6'h00);
			// own slot carries the byte msb first; elsewhere a toggling pattern
			gb_out <= (run && nx[5:3] == PSLOT[2:0]) ? PBYTE[~nx[2:0]] : ~gb_out;
		end
	end
endmodule : alvgbc_peer

// >>> test/alvgbc_regs_tb.sv
/*
 * Self-checking bench for the amplifier configuration bank.
 * Assumes the peer model for TDM timing and gain bus partner traffic.
 */
`timescale 1ns/1ps
module alvgbc_regs_tb;
	logic        clk_sys, nrst, avs_read, avs_write, smp_valid, run, bclk, fsync, pk_out;
	logic [7:0]  avs_address, vcode, vol;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable, limiter_ceiling_db;
	logic        avs_waitrequest, smp_ready, tdm_dout, tdm_dout_oe, gb_out, gb_oe, gb_pin;
	logic        volume_mute, limiter_enable, limiter_rail_select, limiter_headroom_enable;
	logic [23:0] smp_data, a_bits, la_bits;
	logic [7:0]  g_bits, lg_bits;
	logic [17:0] limiter_attack_us_per_db;
	logic [14:0] limiter_release_ms_per_db;
	logic [9:0]  limiter_hold_ms;
	logic [31:0] exp_q[$];
	int          n_errors, total_checks, a_cnt, g_cnt, la_cnt, lg_cnt, own;
	int          hold_tab[8] = '{0, 10, 25, 50, 100, 250, 500, 1000};
	////////////////////////////////////////////////////////////////////////////////
	// released pin reads the peer pattern, never a held value
	assign gb_pin = gb_oe ? gb_out : pk_out;
	alvgbc_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .smp_data(smp_data),
		.smp_valid(smp_valid), .smp_ready(smp_ready), .tdm_bclk(bclk), .tdm_fsync(fsync),
		.tdm_dout(tdm_dout), .tdm_dout_oe(tdm_dout_oe), .inter_chip_gain_bus_in(gb_pin),
		.inter_chip_gain_bus_out(gb_out), .inter_chip_gain_bus_oe(gb_oe), .volume_level_code(vcode),
		.volume_mute(volume_mute), .limiter_enable(limiter_enable), .limiter_rail_select(limiter_rail_select),
		.limiter_headroom_enable(limiter_headroom_enable), .limiter_ceiling_db(limiter_ceiling_db),
		.limiter_attack_us_per_db(limiter_attack_us_per_db),
		.limiter_release_ms_per_db(limiter_release_ms_per_db), .limiter_hold_ms(limiter_hold_ms));
	alvgbc_peer u_peer (.clk_sys(clk_sys), .run(run), .bclk(bclk), .fsync(fsync), .gb_out(pk_out));
	// clock
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask : chk
	// read results are matched against the oldest expectation when they stand
	always @(posedge clk_sys)
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			chk(avs_readdata, exp_q.pop_front());
	// frame bookkeeping: bits driven on each line, sampled mid-bit on the fall
	always @(posedge bclk)
		if (fsync)
		begin
			la_cnt = a_cnt;
			lg_cnt = g_cnt;
			la_bits = a_bits;
			lg_bits = g_bits;
			a_cnt = 0;
			g_cnt = 0;
		end
	always @(negedge bclk)
	begin
		if (tdm_dout_oe === 1'b1)
		begin
			a_bits = {a_bits[22:0], tdm_dout};
			a_cnt++;
		end
		if (gb_oe === 1'b1)
		begin
			g_bits = {g_bits[6:0], gb_out};
			g_cnt++;
		end
	end
	task automatic bus(input logic rw, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		avs_read <= rw;
		avs_write <= !rw;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0)
			@(posedge clk_sys);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b0, idx, d, 4'h1);
	endtask : wr
	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b1, idx, 8'h00, 4'h0);
	endtask : rd
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wait_clk
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	// watchdog, about three and a half times the expected run
	initial
	begin
		wait_clk(40000);
		n_errors++;
		end_of_test();
	end
	// main sequence; host writes only defined codes, reserved bits at reset level
	initial
	begin
		{nrst, avs_read, avs_write, smp_valid, run} = 5'h00;
		{avs_address, avs_writedata, avs_byteenable, smp_data} = '0;
		{a_cnt, g_cnt, la_cnt, lg_cnt, n_errors, total_checks} = '0;
		void'($urandom(32'h305B99A0));
		wait_clk(10);
		nrst <= 1'b1;
		wait_clk(3);
		chk({limiter_rail_select, limiter_headroom_enable, limiter_enable}, 3'b010);
		chk(limiter_ceiling_db, 4'h9);
		chk(limiter_hold_ms, 10'd500);
		chk(limiter_attack_us_per_db, 18'd40);
		chk(limiter_release_ms_per_db, 15'd128);
		chk({vcode, volume_mute}, 9'h000);
		rd(alvgbc_pkg::IDX_TDM_TX, 8'h12);
		rd(alvgbc_pkg::IDX_CEILING, 8'h80);
		rd(alvgbc_pkg::IDX_VOLUME, 8'h00);
		rd(alvgbc_pkg::IDX_LIM_ATK, 8'h62);
		rd(alvgbc_pkg::IDX_LIM_REL, 8'h36);
		rd(alvgbc_pkg::IDX_GBUS, 8'h00);
		rd(6'h30, 8'h00);
		bus(1'b0, alvgbc_pkg::IDX_VOLUME, 8'h33, 4'h0);
		rd(alvgbc_pkg::IDX_VOLUME, 8'h00);
		$display("test reset and access done");
		for (int c = 0; c < 15; c++)
		begin
			wr(alvgbc_pkg::IDX_CEILING, {c[3:0], 4'h0});
			rd(alvgbc_pkg::IDX_CEILING, {c[3:0], 4'h0});
			wait_clk(3);
			chk(limiter_ceiling_db, c + 1);
		end
		for (int c = 0; c < 14; c++)
		begin
			wr(alvgbc_pkg::IDX_LIM_ATK, {c[0], 1'b1, c[1], c[3:0], c[2]});
			wr(alvgbc_pkg::IDX_LIM_REL, {1'b0, c[3:0], 3'(c % 7 + 1)});
			rd(alvgbc_pkg::IDX_LIM_ATK, {c[0], 1'b1, c[1], c[3:0], c[2]});
			wait_clk(3);
			chk({limiter_rail_select, limiter_headroom_enable, limiter_enable}, {c[0], c[1], c[2]});
			chk(limiter_attack_us_per_db, 20 << c);
			chk(limiter_release_ms_per_db, 2 << c);
			chk(limiter_hold_ms, hold_tab[c % 7 + 1]);
		end
		foreach (hold_tab[i])
		begin
			vol = (i < 4) ? 8'(200 - 2 + i) : 8'($urandom_range(0, 255));
			wr(alvgbc_pkg::IDX_VOLUME, vol);
			rd(alvgbc_pkg::IDX_VOLUME, vol);
			wait_clk(3);
			chk({vcode, volume_mute}, {vol, vol > 8'hC8});
		end
		$display("test decode done");
		smp_data <= 24'($urandom());
		smp_valid <= 1'b1;
		wait_clk(4);
		chk(smp_ready, 1'b0);
		run <= 1'b1;
		for (int k = 0; k < 3; k++)
		begin
			own = (k == 2) ? 0 : $urandom_range(0, 3 - 2 * k);
			wr(alvgbc_pkg::IDX_TDM_TX, {k[0], k < 2, 6'(own)});
			wait_clk(3 * 768);
			chk(la_cnt, (k < 2) ? 16 + 8 * k : 0);
			if (k < 2)
				chk(k ? la_bits : la_bits[15:0], k ? smp_data : smp_data[23:8]);
		end
		$display("test audio transmit done");
		own = $urandom_range(0, 6);
		own = (own >= 3) ? own + 1 : own;
		vol = 8'($urandom_range(0, 200));
		wr(alvgbc_pkg::IDX_VOLUME, vol);
		wr(alvgbc_pkg::IDX_GBUS, {1'b1, 4'h3, 3'(own)});
		wait_clk(3 * 768);
		chk(lg_cnt, 8);
		chk(lg_bits, vol);
		wr(alvgbc_pkg::IDX_PARTNER, 8'hFF);
		rd(alvgbc_pkg::IDX_PARTNER, 8'h5A);
		wr(alvgbc_pkg::IDX_GBUS, {1'b0, 4'h3, 3'(own)});
		wait_clk(2 * 768);
		chk(lg_cnt, 0);
		wr(alvgbc_pkg::IDX_PIN_CFG, 8'h10);
		wr(alvgbc_pkg::IDX_PIN_CTL, 8'h01);
		wait_clk(3);
		chk(gb_oe, 1'b0);
		wr(alvgbc_pkg::IDX_GBUS, {1'b1, 4'h3, 3'(own)});
		wait_clk(3);
		chk({gb_oe, gb_out}, 2'b11);
		rd(alvgbc_pkg::IDX_PIN_CTL, 8'h03);
		wr(alvgbc_pkg::IDX_PIN_CFG, 8'h0C);
		wait_clk(3);
		chk(gb_oe, 1'b0);
		wr(alvgbc_pkg::IDX_PIN_CFG, 8'h08);
		wait_clk(3);
		chk(gb_oe, 1'b0);
		$display("test gain bus done");
		end_of_test();
	end
endmodule : alvgbc_regs_tb
